// file: design/ssf_params.svh
// Constants for the stepper status flag bank
// What this block does
// R1 - Pump failure sticky until full status read
// R2 - Electrical defect ORs faults, clears on status reads
// R3 - Summary flag ORs pump, stop, defect, powerup
// R4 - Three-bit motion code, reset stopped
// R5 - Per-coil over-current sticky until full read
// R6 - Safe enable low for one position value
// R7 - Sleep flag set on sleep, bus clears
// R8 - Missed step flag, reset value one
// R9 - Delta high stall flag from comparison
// R10 - Delta low stall flag from comparison
// R11 - Absolute stall flag above threshold
// R12 - Two-bit temperature code, reset normal
// R13 - Shutdown flag clears on read when normal
// R14 - Warning flag clears on read when normal
// R15 - Battery stop flag sticky until status read
// R16 - Power-up marker set, cleared by status reads
// R17 - External switch flag reported in responses
// R18 - Shutdown returns to run after clear
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH
`define SSF_SAFE_POS_OFF 11'h400
`define SSF_MOTION_RST 3'h0
`define SSF_TEMP_RST 2'h0
`define SSF_TEMP_NORMAL 2'h0
`define SSF_TEMP_SHUTDOWN 2'h3
`define SSF_MISSED_STEP_RST 1'h1
`define SSF_BEMF_W 8
`define SSF_THR_W 4
`endif

// file: design/ssf_pkg.sv
// Types for the stepper status flag bank
package ssf_pkg;
    // Device operating state as seen by the flag bank
    typedef enum logic [1:0] {SSF_RUN, SSF_SHUTDOWN} ssf_state_e;
    // Read command kinds
    typedef struct packed {
        logic pos_rd;
        logic stat_rd;
        logic full_rd;
    } ssf_cmd_s;
endpackage : ssf_pkg

// file: design/ssf_cmd_if.sv
// Interface carrying served read commands to the clear logic of the flag bank
`timescale 1ns/1ns
interface ssf_cmd_if;
    logic stat_clr; // Status or full status served
    logic full_clr; // Full status served
    modport src (output stat_clr, output full_clr);
    modport dst (input stat_clr, input full_clr);
endinterface : ssf_cmd_if

// file: design/ssf_sticky.sv
// Sticky flag cell: set wins over clear
`timescale 1ns/1ns
module ssf_sticky #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic set_in,
    input wire logic clr_in,
    output logic flag_out
);
    logic next_flag;
    // Set has priority so an event in the clear cycle survives
    always_comb begin
        next_flag = flag_out;
        if (clr_in) begin
            next_flag = 1'b0;
        end
        if (set_in) begin
            next_flag = 1'b1;
        end
    end
    // Register stage
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_out <= RST_VAL;
        end else begin
            flag_out <= next_flag;
        end
    end
    a_set_wins: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R1 R5
        set_in |=> flag_out) else $error("sticky flag lost a set");
endmodule : ssf_sticky

// file: design/ssf_flags.sv
// Top of the stepper status flag bank
`timescale 1ns/1ns
`include "ssf_params.svh"
module ssf_flags import ssf_pkg::*; #(
    parameter int BEMF_W = `SSF_BEMF_W,
    parameter int THR_W = `SSF_THR_W
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic pump_fail_in,         // Charge pump fault event
    input wire logic coil_x_oc_in,         // Coil X over-current event
    input wire logic coil_y_oc_in,         // Coil Y over-current event
    input wire logic open_x_in,            // Coil X open circuit
    input wire logic open_y_in,            // Coil Y open circuit
    input wire logic batt_low_in,          // Battery at or below stop level
    input wire logic sleep_enter_in,       // Circuit going to sleep
    input wire logic sleep_clr_in,         // Bus command clears sleep flag
    input wire logic step_lost_in,         // Steps lost event
    input wire logic [2:0] motion_in,      // Motion phase from controller
    input wire logic [1:0] temp_code_in,   // Temperature code
    input wire logic over_shut_temp_in,    // Above shutdown temperature
    input wire logic over_warn_temp_in,    // Above warning temperature
    input wire logic ext_switch_in,        // External switch pin, async
    input wire logic [10:0] safe_position_in,
    input wire logic [BEMF_W-1:0] bemf_in, // Measured back-EMF
    input wire logic [BEMF_W-1:0] bemf_avg_in,
    input wire logic [THR_W-1:0] delta_stall_threshold_in,
    input wire logic [THR_W-1:0] absolute_stall_threshold_in,
    input wire logic bemf_valid_in,        // Compare strobe
    input wire logic position_read_in,     // Position read served
    input wire logic status_read_in,       // Status read served
    input wire logic full_status_read_in,  // Full status read served
    output logic pump_fail_out,
    output logic coil_x_overcurrent_out,
    output logic coil_y_overcurrent_out,
    output logic electrical_defect_out,
    output logic electrical_summary_flag_out,
    output logic battery_stop_flag_out,
    output logic powerup_flag_out,
    output logic sleep_flag_out,
    output logic missed_step_flag_out,
    output logic delta_high_stall_out,
    output logic delta_low_stall_out,
    output logic absolute_stall_out,
    output logic thermal_shutdown_out,
    output logic thermal_warning_flag_out,
    output logic [2:0] motion_out,
    output logic [1:0] temp_code_out,
    output logic ext_switch_flag_out,
    output logic safe_enable_out,
    output logic shutdown_state_out        // High while in shutdown state
);
    ////////////////////////////////////////////////////////////////////////
    // Command decode
    ssf_cmd_if cmd ();
    ssf_cmd_s rd;
    assign rd = '{pos_rd: position_read_in, stat_rd: status_read_in, full_rd: full_status_read_in};
    assign cmd.stat_clr = rd.stat_rd | rd.full_rd;
    assign cmd.full_clr = rd.full_rd;
    logic temp_normal;
    assign temp_normal = (temp_code_in == `SSF_TEMP_NORMAL);

    ////////////////////////////////////////////////////////////////////////
    // Sticky fault cells
    logic defect_src;
    // R2 defect source terms
    assign defect_src = coil_x_oc_in | coil_y_oc_in | open_x_in | open_y_in | pump_fail_in;
    logic [3:0] st_set;
    logic [3:0] st_clr;
    logic [3:0] st_q;
    // R1 pump cleared by full read
    // R5 coils cleared by full read
    assign st_set = {coil_y_oc_in, coil_x_oc_in, pump_fail_in, defect_src};
    assign st_clr = {cmd.full_clr, cmd.full_clr, cmd.full_clr, cmd.stat_clr};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sticky
            ssf_sticky #(.RST_VAL(1'b0)) u_cell (
                .sys_clk_in(sys_clk_in),
                .rst_n_in(rst_n_in),
                .set_in(st_set[gi]),
                .clr_in(st_clr[gi]),
                .flag_out(st_q[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Switch synchroniser: three stages, change accepted when last two agree
    logic [2:0] sw_sync;
    logic [2:0] next_sw_sync;
    logic sw_flag;
    logic next_sw_flag;
    // Shift pin through the chain
    always_comb begin
        next_sw_sync = {sw_sync[1:0], ext_switch_in};
        next_sw_flag = sw_flag;
        if (sw_sync[1] == sw_sync[2]) begin
            next_sw_flag = sw_sync[2];
        end
    end
    // Register synchroniser
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sw_sync <= 3'h0;
            sw_flag <= 1'b0;
        end else begin
            sw_sync <= next_sw_sync;
            sw_flag <= next_sw_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Remaining flags and state
    logic pwrup;
    logic next_pwrup;
    logic batt;
    logic next_batt;
    logic slp;
    logic next_slp;
    logic mstep;
    logic next_mstep;
    logic dhi;
    logic next_dhi;
    logic dlo;
    logic next_dlo;
    logic abst;
    logic next_abst;
    logic tsd;
    logic next_tsd;
    logic twn;
    logic next_twn;
    ssf_state_e state;
    ssf_state_e next_state;
    logic summary;
    logic next_summary; // Summary as it reads after this cycle's clears
    logic [BEMF_W:0] hi_lim;
    logic [BEMF_W:0] lo_lim;
    // Compare limits, one bit wider so the sum cannot wrap
    assign hi_lim = {1'b0, bemf_avg_in} + {{(BEMF_W+1-THR_W){1'b0}}, delta_stall_threshold_in};
    assign lo_lim = {1'b0, bemf_avg_in} - {{(BEMF_W+1-THR_W){1'b0}}, delta_stall_threshold_in};
    // R3 electrical summary
    assign summary = st_q[1] | batt | st_q[0] | pwrup;

    // Next values; set terms come last so they win over clears
    always_comb begin
        next_pwrup = pwrup;
        next_batt = batt;
        next_slp = slp;
        next_mstep = mstep;
        next_dhi = dhi;
        next_dlo = dlo;
        next_abst = abst;
        next_tsd = tsd;
        next_twn = twn;
        next_state = state;
        // R16 marker cleared by status reads
        if (cmd.stat_clr) begin
            next_pwrup = 1'b0;
        end
        // R15 battery stop sticky
        if (cmd.stat_clr) begin
            next_batt = 1'b0;
        end
        if (batt_low_in) begin
            next_batt = 1'b1;
        end
        // R7 sleep flag
        if (sleep_clr_in) begin
            next_slp = 1'b0;
        end
        if (sleep_enter_in) begin
            next_slp = 1'b1;
        end
        // R8 missed step, cleared by status reads
        if (cmd.stat_clr) begin
            next_mstep = 1'b0;
        end
        if (step_lost_in) begin
            next_mstep = 1'b1;
        end
        // R9 R10 R11 stall flags, cleared by full read
        if (cmd.full_clr) begin
            next_dhi = 1'b0;
            next_dlo = 1'b0;
            next_abst = 1'b0;
        end
        if (bemf_valid_in) begin
            if ({1'b0, bemf_in} > hi_lim) begin
                next_dhi = 1'b1;
            end
            // A negative limit lies below every reading, so it always sets
            if (lo_lim[BEMF_W] || ({1'b0, bemf_in} > lo_lim)) begin
                next_dlo = 1'b1;
            end
            if (bemf_in > BEMF_W'(absolute_stall_threshold_in)) begin
                next_abst = 1'b1;
            end
        end
        // R13 R14 thermal clear only at normal temperature
        if (cmd.stat_clr && temp_normal) begin
            next_tsd = 1'b0;
            next_twn = 1'b0;
        end
        if (over_shut_temp_in) begin
            next_tsd = 1'b1;
        end
        if (over_warn_temp_in) begin
            next_twn = 1'b1;
        end
        // R18 summary seen after the clear attempt, same terms as R3
        next_summary = (st_set[1] | (st_q[1] & !st_clr[1])) | next_batt
            | (st_set[0] | (st_q[0] & !st_clr[0])) | next_pwrup;
        // Shutdown entry on thermal shutdown flag or shutdown temperature code
        case (state)
            SSF_RUN: begin
                if (tsd || temp_code_in == `SSF_TEMP_SHUTDOWN) begin
                    next_state = SSF_SHUTDOWN;
                end
            end
            SSF_SHUTDOWN: begin
                // R18 leave shutdown only when both flags read zero
                if (cmd.stat_clr && !next_tsd && !next_summary) begin
                    next_state = SSF_RUN;
                end
            end
            default: begin
                next_state = SSF_RUN;
            end
        endcase
    end

    // Register flags and state
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwrup <= 1'b1;
            batt <= 1'b0;
            slp <= 1'b0;
            mstep <= `SSF_MISSED_STEP_RST;
            dhi <= 1'b0;
            dlo <= 1'b0;
            abst <= 1'b0;
            tsd <= 1'b0;
            twn <= 1'b0;
            state <= SSF_RUN;
        end else begin
            pwrup <= next_pwrup;
            batt <= next_batt;
            slp <= next_slp;
            mstep <= next_mstep;
            dhi <= next_dhi;
            dlo <= next_dlo;
            abst <= next_abst;
            tsd <= next_tsd;
            twn <= next_twn;
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            motion_out <= `SSF_MOTION_RST;
            temp_code_out <= `SSF_TEMP_RST;
            safe_enable_out <= 1'b0;
            electrical_summary_flag_out <= 1'b0;
            shutdown_state_out <= 1'b0;
        end else begin
            // R4 motion code passes through
            motion_out <= motion_in;
            // R12 temperature code
            temp_code_out <= temp_code_in;
            // R6 safe enable decode
            safe_enable_out <= (safe_position_in != `SSF_SAFE_POS_OFF);
            electrical_summary_flag_out <= summary;
            // State flag registered from the next state, so it shows with the state
            shutdown_state_out <= (next_state == SSF_SHUTDOWN);
        end
    end
    // Flags already come from flops
    assign pump_fail_out = st_q[1];
    assign coil_x_overcurrent_out = st_q[2];
    assign coil_y_overcurrent_out = st_q[3];
    assign electrical_defect_out = st_q[0];
    assign battery_stop_flag_out = batt;
    assign powerup_flag_out = pwrup;
    assign sleep_flag_out = slp;
    assign missed_step_flag_out = mstep;
    assign delta_high_stall_out = dhi;
    assign delta_low_stall_out = dlo;
    assign absolute_stall_out = abst;
    assign thermal_shutdown_out = tsd;
    assign thermal_warning_flag_out = twn;
    // R17 switch flag reported
    assign ext_switch_flag_out = sw_flag;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_pump_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R1
        pump_fail_out && !full_status_read_in |=> pump_fail_out) else $error("pump flag dropped early");
    a_defect_or: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R2
        open_x_in |=> electrical_defect_out) else $error("defect missed open circuit");
    a_summary_or: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R3
        rst_n_in |=> electrical_summary_flag_out == $past(pump_fail_out | battery_stop_flag_out
        | electrical_defect_out | powerup_flag_out)) else $error("summary not the or of its flags");
    a_motion_copy: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R4
        rst_n_in |=> motion_out == $past(motion_in)) else $error("motion code wrong");
    a_coil_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R5
        coil_x_overcurrent_out && status_read_in && !full_status_read_in |=> coil_x_overcurrent_out)
        else $error("coil flag cleared by status read");
    a_safe_decode: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R6
        safe_position_in == 11'h400 |=> !safe_enable_out) else $error("safe enable wrong");
    a_sleep_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R7
        sleep_enter_in |=> sleep_flag_out) else $error("sleep flag not set");
    a_thermal_keep: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R13
        thermal_shutdown_out && temp_code_in != 2'h0 |=> thermal_shutdown_out) else $error("tsd cleared hot");
    a_batt_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R15
        batt_low_in |=> battery_stop_flag_out) else $error("battery flag not set");
    a_power_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R16
        status_read_in |=> !powerup_flag_out) else $error("powerup marker not cleared");
    a_switch_lag: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R17
        ext_switch_in [*5] |-> ext_switch_flag_out) else $error("switch flag slow");
endmodule : ssf_flags

// file: test/ssf_bus_master.sv
// Bus master model that serves read commands to the flag bank
`timescale 1ns/1ns
module ssf_bus_master (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    output logic pos_rd_out,
    output logic stat_rd_out,
    output logic full_rd_out
);
    // Idle: no command served
    initial begin
        pos_rd_out = 1'b0;
        stat_rd_out = 1'b0;
        full_rd_out = 1'b0;
    end

    // One served read; kind 1 position, 2 status, 3 full status
    // Never issued in reset, so a clear cannot hide behind it
    task automatic serve(input logic [1:0] kind);
        wait (rst_n_in === 1'b1);
        @(posedge sys_clk_in);
        pos_rd_out <= (kind == 2'h1);
        stat_rd_out <= (kind == 2'h2);
        full_rd_out <= (kind == 2'h3);
        @(posedge sys_clk_in);
        pos_rd_out <= 1'b0;
        stat_rd_out <= 1'b0;
        full_rd_out <= 1'b0;
    endtask : serve
endmodule : ssf_bus_master

// file: test/testbench.sv
// Self-checking bench for the stepper status flag bank
`timescale 1ns/1ns
module testbench;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [9:0] ev = 10'h000;
    logic pump_fail_in, coil_x_oc_in, coil_y_oc_in, open_x_in, open_y_in, batt_low_in;
    logic sleep_enter_in, step_lost_in, over_shut_temp_in, over_warn_temp_in;
    logic sleep_clr_in = 1'b0;
    logic bemf_valid_in = 1'b0;
    logic ext_switch_in = 1'b0;
    logic [2:0] motion_in = 3'h0;
    logic [1:0] temp_code_in = 2'h0;
    logic [10:0] safe_position_in = 11'h000;
    logic [7:0] bemf_in = 8'h00;
    logic [7:0] bemf_avg_in = 8'h00;
    logic [3:0] delta_stall_threshold_in = 4'h4;
    logic [3:0] absolute_stall_threshold_in = 4'h8;
    logic position_read_in, status_read_in, full_status_read_in;
    logic pump_fail_out, coil_x_overcurrent_out, coil_y_overcurrent_out, electrical_defect_out;
    logic electrical_summary_flag_out, battery_stop_flag_out, powerup_flag_out, sleep_flag_out;
    logic missed_step_flag_out, delta_high_stall_out, delta_low_stall_out, absolute_stall_out;
    logic thermal_shutdown_out, thermal_warning_flag_out, ext_switch_flag_out, safe_enable_out;
    logic shutdown_state_out;
    logic [2:0] motion_out;
    logic [1:0] temp_code_out;
    logic [13:0] fl; // All flags but the switch flag in one word
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    localparam logic [13:0] F_SUM = 14'h2000, F_PF = 14'h1000, F_CX = 14'h0800, F_CY = 14'h0400,
        F_DF = 14'h0200, F_BS = 14'h0100, F_PW = 14'h0080, F_SL = 14'h0040, F_MS = 14'h0020,
        F_TS = 14'h0010, F_TW = 14'h0008, F_DH = 14'h0004, F_DL = 14'h0002, F_AB = 14'h0001;
    localparam logic [9:0] I_PF = 10'h200, I_CX = 10'h100, I_CY = 10'h080, I_OX = 10'h040,
        I_OY = 10'h020, I_BS = 10'h010, I_SL = 10'h008, I_MS = 10'h004, I_TS = 10'h002, I_TW = 10'h001;
    // Event pulsed, read served, flags after event, flags after read
    typedef struct packed {
        logic [9:0] ev;
        logic [1:0] rd;
        logic [13:0] e1;
        logic [13:0] e2;
    } ssf_row_s;
    localparam ssf_row_s ROWS [0:11] = '{
        '{I_PF, 2'h1, F_PF | F_DF | F_SUM, F_PF | F_DF | F_SUM},
        '{I_PF, 2'h3, F_PF | F_DF | F_SUM, 14'h0},
        '{I_OX, 2'h2, F_DF | F_SUM, 14'h0},
        '{I_OY, 2'h3, F_DF | F_SUM, 14'h0},
        '{I_CX, 2'h3, F_CX | F_DF | F_SUM, 14'h0},
        '{I_CY, 2'h3, F_CY | F_DF | F_SUM, 14'h0},
        '{I_BS, 2'h2, F_BS | F_SUM, 14'h0},
        '{I_BS, 2'h1, F_BS | F_SUM, F_BS | F_SUM},
        '{I_SL, 2'h2, F_SL, F_SL},
        '{I_MS, 2'h2, F_MS, 14'h0},
        '{I_TS, 2'h3, F_TS, 14'h0},
        '{I_TW, 2'h2, F_TW, 14'h0}
    };
    // Back-EMF, average, expected stall flags; delta 4, absolute 8
    localparam logic [29:0] ST [0:3] = '{{8'h20, 8'h10, F_DH | F_DL | F_AB}, {8'h14, 8'h10, F_DL | F_AB},
        {8'h08, 8'h10, 14'h0}, {8'h03, 8'h02, F_DL}};
    localparam logic [10:0] SP [0:3] = '{11'h400, 11'h3ff, 11'h401, 11'h000};

    assign {pump_fail_in, coil_x_oc_in, coil_y_oc_in, open_x_in, open_y_in, batt_low_in,
        sleep_enter_in, step_lost_in, over_shut_temp_in, over_warn_temp_in} = ev;
    assign fl = {electrical_summary_flag_out, pump_fail_out, coil_x_overcurrent_out, coil_y_overcurrent_out,
        electrical_defect_out, battery_stop_flag_out, powerup_flag_out, sleep_flag_out, missed_step_flag_out,
        thermal_shutdown_out, thermal_warning_flag_out, delta_high_stall_out, delta_low_stall_out,
        absolute_stall_out};

    ssf_flags u_dut (.*);
    ssf_bus_master u_bm (.sys_clk_in, .rst_n_in, .pos_rd_out(position_read_in),
        .stat_rd_out(status_read_in), .full_rd_out(full_status_read_in));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, 100 ns period
    always #50 sys_clk_in = ~sys_clk_in;

    // Compare and count
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Let n edges pass, then look at the falling edge where all is settled
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
    endtask : settle

    // One-cycle event on the chosen inputs
    task automatic pulse(input logic [9:0] m);
        @(posedge sys_clk_in);
        ev <= m;
        @(posedge sys_clk_in);
        ev <= 10'h000;
        settle(2);
    endtask : pulse

    // Clear every flag between cases; sleep needs its own command
    task automatic clean();
        u_bm.serve(2'h3);
        @(posedge sys_clk_in);
        sleep_clr_in <= 1'b1;
        @(posedge sys_clk_in);
        sleep_clr_in <= 1'b0;
        settle(2);
    endtask : clean

    task automatic stop_test();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk(fl, F_PW | F_MS);
        chk({9'h0, motion_out, temp_code_out}, 14'h0);
        @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        settle(2);
        chk(fl, F_SUM | F_PW | F_MS);
        u_bm.serve(2'h2);
        settle(2);
        chk(fl, 14'h0);
        foreach (ROWS[i]) begin
            pulse(ROWS[i].ev);
            chk(fl, ROWS[i].e1);
            u_bm.serve(ROWS[i].rd);
            settle(2);
            chk(fl, ROWS[i].e2);
            clean();
            chk(fl, 14'h0);
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk_in);
            motion_in <= 3'(i);
            settle(2);
            chk({11'h0, motion_out}, 14'(i));
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk_in);
            temp_code_in <= 2'(i);
            settle(2);
            chk({12'h0, temp_code_out}, 14'(i));
        end
        chk({13'h0, shutdown_state_out}, 14'h1);
        @(posedge sys_clk_in);
        temp_code_in <= 2'h1;
        pulse(I_TS | I_TW);
        u_bm.serve(2'h2);
        settle(0);
        chk({13'h0, shutdown_state_out}, 14'h1);
        settle(1);
        chk(fl, F_TS | F_TW);
        @(posedge sys_clk_in);
        temp_code_in <= 2'h0;
        u_bm.serve(2'h2);
        settle(2);
        chk(fl, 14'h0);
        chk({13'h0, shutdown_state_out}, 14'h0);
        // set wins over a clear in the same cycle
        @(posedge sys_clk_in);
        ev <= I_PF;
        u_bm.serve(2'h3);
        settle(0);
        chk(fl, F_PF | F_DF | F_SUM);
        @(posedge sys_clk_in);
        ev <= 10'h000;
        clean();
        foreach (SP[i]) begin
            @(posedge sys_clk_in);
            safe_position_in <= SP[i];
            settle(2);
            chk({13'h0, safe_enable_out}, {13'h0, (i != 0)});
        end
        // stall compares, only on the strobe
        @(posedge sys_clk_in);
        bemf_in <= 8'hff;
        settle(2);
        chk(fl, 14'h0);
        foreach (ST[i]) begin
            @(posedge sys_clk_in);
            bemf_in <= ST[i][29:22];
            bemf_avg_in <= ST[i][21:14];
            bemf_valid_in <= 1'b1;
            @(posedge sys_clk_in);
            bemf_valid_in <= 1'b0;
            settle(2);
            chk(fl, ST[i][13:0]);
            clean();
        end
        @(posedge sys_clk_in);
        ext_switch_in <= 1'b1;
        settle(5);
        chk({13'h0, ext_switch_flag_out}, 14'h1);
        @(posedge sys_clk_in);
        ext_switch_in <= 1'b0;
        settle(5);
        chk({13'h0, ext_switch_flag_out}, 14'h0);
        pulse(I_PF);
        @(posedge sys_clk_in);
        rst_n_in <= 1'b0;
        settle(1);
        chk(fl, F_PW | F_MS);
        @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        settle(2);
        chk(fl, F_SUM | F_PW | F_MS);
        stop_test();
    end
endmodule : testbench
